// File: design/sfr_pkg.sv
// Shared constants for the fault-reporting serial slave port
package sfr_pkg;
	localparam int FRAME_BITS = 16;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] FRAME_CNT = 5'h10;
	localparam logic [CNT_W-1:0] CNT_SAT = 5'h11;
	localparam int PAR_BIT = 15;
	localparam int DIR_BIT = 14;
	localparam int MSG_HI = 13;
	localparam int MSG_LO = 9;
	localparam int DATA_W = 9;
	localparam logic [15:0] FIRST_REPLY = 16'haaaa;
	localparam logic [15:0] REJECT_REPLY = 16'hc000;
	localparam logic [4:0] STATUS_MSG = 5'h00;
	localparam logic [15:0] TX_RST = FIRST_REPLY;
	localparam int CLK_MHZ = 125;
	localparam int T1_NS = 1000;
	localparam int T1_CYC = (T1_NS * CLK_MHZ + 999) / 1000;
	localparam int T2_NS = 20000;
	localparam int T2_CYC = (T2_NS * CLK_MHZ) / 1000;
	localparam int AUX_MHZ = 14;
	localparam int AUX_EXP = (T2_NS * AUX_MHZ) / 1000;
	localparam int AUX_LO = (AUX_EXP * 3) / 4;
	localparam int AUX_HI = (AUX_EXP * 5) / 4;
	localparam int MON_W = 16;
	localparam logic [7:0] RST_REC_CYC = 8'h10;
endpackage

// File: design/sfr_clkmon.sv
// Oscillator cross-check: stall and frequency-mismatch detection
`timescale 1ns/1ps
`default_nettype none
module sfr_clkmon
	import sfr_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic aux_clk_i,
	input wire logic enable_i,
	output logic clk_fault_o
);
	logic [1:0] aux_rst_ff;
	logic aux_tog_ff;
	logic tog_m_ff, tog_s_ff, tog_d_ff;
	logic [MON_W-1:0] stall_ff, win_ff, edges_ff;
	logic aux_edge;

	// Reset reaches the aux domain through its own two stages
	always_ff @(posedge aux_clk_i) begin
		aux_rst_ff <= {aux_rst_ff[0], rst_b_i};
	end

	always_ff @(posedge aux_clk_i) begin
		if (!aux_rst_ff[1]) begin
			aux_tog_ff <= 1'b0;
		end else begin
			aux_tog_ff <= ~aux_tog_ff;
		end
	end

	always_ff @(posedge clock_i) begin
		tog_m_ff <= aux_tog_ff;
		tog_s_ff <= tog_m_ff;
		tog_d_ff <= tog_s_ff;
	end

	assign aux_edge = tog_s_ff ^ tog_d_ff;

	// Stall and window counters restart while monitoring is off
	always_ff @(posedge clock_i) begin
		if (!rst_b_i || !enable_i) begin
			stall_ff <= '0;
			win_ff <= '0;
			edges_ff <= '0;
			clk_fault_o <= 1'b0;
		end else begin
			clk_fault_o <= 1'b0;
			stall_ff <= aux_edge ? '0 : stall_ff + 16'h0001;
			if (stall_ff >= MON_W'(T1_CYC)) begin
				clk_fault_o <= 1'b1;
				stall_ff <= '0;
			end
			if (win_ff == MON_W'(T2_CYC - 1)) begin
				win_ff <= '0;
				edges_ff <= '0;
				// One decision per window, so the worst case is two windows
				if (edges_ff < MON_W'(AUX_LO) || edges_ff > MON_W'(AUX_HI)) begin
					clk_fault_o <= 1'b1;
				end
			end else begin
				win_ff <= win_ff + 16'h0001;
				edges_ff <= edges_ff + MON_W'(aux_edge);
			end
		end
	end
endmodule
`default_nettype wire

// File: design/sfr_spi_slave.sv
// Serial slave port with framing checks, parity and two-stage fault flags
// How it works
// - frames are sixteen bits, MSB first
// - input bits sampled on serial clock rise
// - output bit changes on serial clock fall
// - bad count or parity discards the command
// - bit fifteen makes the word even parity
// - reply bit fourteen flags previous bad frame
// - after reject reply is flag, parity only
// - first reply after reset is alternating pattern
// - stage one latches fault when detected
// - stage one clears when gone and delivered
// - stage two copies stage one on deselect
// - stage two feeds the reply only after status read
// - clear bit resets flag one clock, if fault gone
// - clear bit drops itself next clock
// - stopped oscillator forces reset, sets flag
// - mismatch checked once per comparison window
// - reset and clock flags clear on read
`timescale 1ns/1ps
`default_nettype none
module sfr_spi_slave
	import sfr_pkg::*;
#(
	parameter int NFLT = 8
)
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic sclk_i,
	input wire logic chip_select_n_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_b_o,
	input wire logic aux_clk_i,
	input wire logic [NFLT-1:0] fault_i,
	output logic wr_valid_o,
	output logic [4:0] wr_msg_o,
	output logic [DATA_W-1:0] wr_data_o,
	output logic [NFLT-1:0] clr_flt_o,
	output logic [NFLT-1:0] flt_status_o,
	output logic reset_out_n_o
);
	// Link side (serial clock domain)
	logic [CNT_W-1:0] rcnt_ff, fcnt_ff;
	logic [15:0] rx_ff;
	logic so_ff;
	// Core side
	logic arm_ff;
	logic cs_m_ff, cs_s_ff, cs_d_ff;
	logic [NFLT-1:0] flt_m_ff, flt_s_ff;
	logic [NFLT-1:0] st1_ff, st2_ff, dlv_ff, clr_ff;
	logic [15:0] tx_word_ff;
	logic sent_stat_ff, ld_stat_ff;
	logic rst_flag_ff, clk_flt_ff;
	logic [7:0] rec_ff;
	logic core_rst, cs_rise, frame_ok, shipped, clk_fault;
	logic [4:0] rx_msg;
	logic [NFLT-1:0] shipped_flt;

	function automatic logic [15:0] mk_reply(input logic [14:0] body);
		mk_reply = {^body, body};
	endfunction

	assign core_rst = !rst_b_i || !reset_out_n_o;

	// Serial clock is not free-running: counters are cleared from the core side
	// between frames, so no edge outside a frame is needed.
	always_ff @(posedge sclk_i or posedge arm_ff) begin
		if (arm_ff) begin
			rcnt_ff <= '0;
			rx_ff <= '0;
		end else begin
			rx_ff <= {rx_ff[14:0], si_i};
			if (rcnt_ff != CNT_SAT) begin
				rcnt_ff <= rcnt_ff + 5'h01;
			end
		end
	end

	always_ff @(negedge sclk_i or posedge arm_ff) begin
		if (arm_ff) begin
			fcnt_ff <= '0;
			so_ff <= 1'b0;
		end else begin
			if (fcnt_ff != CNT_SAT) begin
				fcnt_ff <= fcnt_ff + 5'h01;
			end
			if (fcnt_ff < 5'h0f) begin
				so_ff <= tx_word_ff[4'(5'h0e - fcnt_ff)];
			end else begin
				so_ff <= 1'b0;
			end
		end
	end

	// MSB must be on the pin before the first falling edge exists
	assign so_o = (fcnt_ff == 5'h00) ? tx_word_ff[PAR_BIT] : so_ff;
	assign so_oe_b_o = chip_select_n_i;

	// Select and fault pins pass two stages before use
	always_ff @(posedge clock_i) begin
		cs_m_ff <= chip_select_n_i;
		cs_s_ff <= cs_m_ff;
		cs_d_ff <= cs_s_ff;
		flt_m_ff <= fault_i;
		flt_s_ff <= flt_m_ff;
	end

	assign cs_rise = cs_s_ff && !cs_d_ff;
	// Link words are stable here: the serial clock is idle once select is high
	assign frame_ok = (rcnt_ff == FRAME_CNT) && !(^rx_ff);
	assign rx_msg = rx_ff[MSG_HI:MSG_LO];
	assign shipped = cs_rise && (rcnt_ff >= FRAME_CNT);
	assign shipped_flt = (shipped && sent_stat_ff) ? tx_word_ff[NFLT-1:0] : '0;

	// Link counters held clear from frame capture until the next select
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			arm_ff <= 1'b1;
		end else if (cs_rise) begin
			arm_ff <= 1'b1;
		end else if (!cs_s_ff) begin
			arm_ff <= 1'b0;
		end
	end

	// Command decode
	always_ff @(posedge clock_i) begin
		if (core_rst) begin
			wr_valid_o <= 1'b0;
			wr_msg_o <= '0;
			wr_data_o <= '0;
		end else begin
			wr_valid_o <= 1'b0;
			if (cs_rise && frame_ok && rx_ff[DIR_BIT]) begin
				wr_valid_o <= 1'b1;
				wr_msg_o <= rx_msg;
				wr_data_o <= rx_ff[DATA_W-1:0];
			end
		end
	end

	// Fault-clear bits live for exactly one clock
	always_ff @(posedge clock_i) begin
		if (core_rst) begin
			clr_ff <= '0;
		end else if (cs_rise && frame_ok && rx_ff[DIR_BIT] && rx_msg == STATUS_MSG) begin
			clr_ff <= rx_ff[NFLT-1:0];
		end else begin
			clr_ff <= '0;
		end
	end

	assign clr_flt_o = clr_ff;

	// Per-fault two-stage latching
	genvar gi;
	generate
		for (gi = 0; gi < NFLT; gi++) begin : g_flt
			always_ff @(posedge clock_i) begin
				if (core_rst) begin
					st1_ff[gi] <= 1'b0;
					dlv_ff[gi] <= 1'b0;
				end else if (flt_s_ff[gi]) begin
					st1_ff[gi] <= 1'b1;
					dlv_ff[gi] <= dlv_ff[gi] | shipped_flt[gi];
				end else if (clr_ff[gi] || dlv_ff[gi]) begin
					st1_ff[gi] <= 1'b0;
					dlv_ff[gi] <= 1'b0;
				end else begin
					dlv_ff[gi] <= shipped_flt[gi] & st1_ff[gi];
				end
			end

			always_ff @(posedge clock_i) begin
				if (core_rst) begin
					st2_ff[gi] <= 1'b0;
				end else if (cs_rise) begin
					st2_ff[gi] <= st1_ff[gi];
				end
			end
		end
	endgenerate

	assign flt_status_o = st1_ff;

	// Reply word, prepared between frames
	always_ff @(posedge clock_i) begin
		if (core_rst) begin
			tx_word_ff <= TX_RST;
			sent_stat_ff <= 1'b0;
			ld_stat_ff <= 1'b0;
		end else begin
			ld_stat_ff <= 1'b0;
			if (cs_rise) begin
				sent_stat_ff <= 1'b0;
				if (!frame_ok) begin
					tx_word_ff <= REJECT_REPLY;
				end else if (!rx_ff[DIR_BIT] && rx_msg == STATUS_MSG) begin
					ld_stat_ff <= 1'b1;
				end else begin
					tx_word_ff <= mk_reply({1'b0, rx_msg, 9'h000});
				end
			end
			// Loaded a clock later so the stage-two copy has settled
			if (ld_stat_ff) begin
				tx_word_ff <= mk_reply({1'b0, rst_flag_ff, clk_flt_ff, 4'h0,
					8'(st2_ff)});
				sent_stat_ff <= 1'b1;
			end
		end
	end

	// Clear-on-read flags; a new event in the read cycle wins
	always_ff @(posedge clock_i) begin
		if (core_rst) begin
			rst_flag_ff <= 1'b1;
		end else if (shipped && sent_stat_ff && tx_word_ff[13]) begin
			rst_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			clk_flt_ff <= 1'b0;
		end else if (clk_fault) begin
			clk_flt_ff <= 1'b1;
		end else if (shipped && sent_stat_ff && tx_word_ff[12]) begin
			clk_flt_ff <= 1'b0;
		end
	end

	// Clock fault drives the reset pin low for a recovery period
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			reset_out_n_o <= 1'b1;
			rec_ff <= '0;
		end else if (clk_fault) begin
			reset_out_n_o <= 1'b0;
			rec_ff <= RST_REC_CYC;
		end else if (rec_ff != 8'h00) begin
			rec_ff <= rec_ff - 8'h01;
		end else begin
			reset_out_n_o <= 1'b1;
		end
	end

	// Main oscillator loss cannot be seen from itself; aux is the reference
	sfr_clkmon u_clkmon (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.aux_clk_i(aux_clk_i),
		.enable_i(!clk_flt_ff && reset_out_n_o),
		.clk_fault_o(clk_fault)
	);

	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	first_reply_a: assert property ($rose(rst_b_i) |-> tx_word_ff == FIRST_REPLY)
		else $error("first reply not the alternating pattern");
	reject_reply_a: assert property (cs_rise && !frame_ok && reset_out_n_o
		|=> tx_word_ff == REJECT_REPLY)
		else $error("rejected frame reply wrong");
	bad_frame_a: assert property (cs_rise && !frame_ok |=> !wr_valid_o)
		else $error("bad frame was applied");
	clr_width_a: assert property (clr_ff != '0 |=> clr_ff == '0)
		else $error("clear bit held too long");
	clr_after_frame_a: assert property (cs_rise && frame_ok && rx_ff[DIR_BIT]
		&& rx_msg == STATUS_MSG && reset_out_n_o |=> clr_ff == $past(rx_ff[NFLT-1:0]))
		else $error("clear bits not applied after frame");
	stage_copy_a: assert property (cs_rise && reset_out_n_o
		|=> st2_ff == $past(st1_ff))
		else $error("stage two missed the copy");
	fault_catch_a: assert property (flt_s_ff[0] && reset_out_n_o |=> st1_ff[0])
		else $error("fault not latched");
	status_load_a: assert property (ld_stat_ff && reset_out_n_o
		|=> tx_word_ff[7:0] == 8'($past(st2_ff)) && !(^tx_word_ff))
		else $error("status reply not loaded from stage two");
	clk_reset_a: assert property (clk_fault |=> !reset_out_n_o && clk_flt_ff)
		else $error("clock fault did not reset");
	rst_read_a: assert property (shipped && sent_stat_ff && tx_word_ff[13] && !core_rst
		|=> !rst_flag_ff)
		else $error("reset flag kept after read");
	clk_read_a: assert property (shipped && sent_stat_ff && tx_word_ff[12] && !clk_fault
		|=> !clk_flt_ff)
		else $error("clock flag kept after read");
	even_parity_a: assert property (@(posedge sclk_i) disable iff (arm_ff)
		!(^tx_word_ff))
		else $error("reply word parity odd");
endmodule
`default_nettype wire

// File: tb/sfr_host_model.sv
// Host master model that frames words onto the serial port
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
	input wire logic lclk_i,
	input wire logic so_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic si_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge lclk_i);
	endtask
	// Ten link ticks per serial period keep it near 8.3 MHz
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
		r = 16'h0000;
		tick(1);
		cs_n_o <= 1'b0;
		tick(5);
		for (int i = 0; i < n; i++) begin
			si_o <= w[15 - i % 16];
			tick(5);
			sclk_o <= 1'b1;
			r = {r[14:0], so_i};
			tick(5);
			sclk_o <= 1'b0;
		end
		tick(3);
		cs_n_o <= 1'b1;
		// Released data line shows the inverse of its last bit
		si_o <= ~si_o;
		tick(20);
	endtask
endmodule
`default_nettype wire

// File: tb/spi_slave_fault_reporting_tb.sv
// Self-checking bench for the fault-reporting serial slave port
`timescale 1ns/1ps
`default_nettype none
module spi_slave_fault_reporting_tb;
	import sfr_pkg::*;
	logic clock_i = 1'b0;
	logic lclk = 1'b0;
	logic aux = 1'b0;
	logic aux_run = 1'b1;
	logic rst_b = 1'b0;
	logic [7:0] flt = 8'h00;
	logic sclk, cs_n, si, so, oe_b, wv, rout_n, so_w;
	logic [4:0] wm, l_msg;
	logic [8:0] wd, l_data;
	logic [7:0] clr, st, l_clr, f, c;
	logic [15:0] r, e, w;
	int aux_half = 36;
	int n_fail = 0;
	int tests_run = 0;
	int n_wr, n_clr, n_lo, j, k;
	assign so_w = oe_b ? ~so : so;
	sfr_spi_slave #(.NFLT(8)) dut_u (.clock_i(clock_i), .rst_b_i(rst_b), .sclk_i(sclk),
		.chip_select_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_b_o(oe_b), .aux_clk_i(aux),
		.fault_i(flt), .wr_valid_o(wv), .wr_msg_o(wm), .wr_data_o(wd), .clr_flt_o(clr),
		.flt_status_o(st), .reset_out_n_o(rout_n));
	sfr_host_model host_u (.lclk_i(lclk), .so_i(so_w), .sclk_o(sclk), .cs_n_o(cs_n),
		.si_o(si));
	initial forever #4 clock_i = ~clock_i;
	// Odd offset keeps the link clock unrelated in phase
	initial begin
		#1.7;
		forever #6 lclk = ~lclk;
	end
	initial forever begin
		#(aux_half);
		if (aux_run)
			aux = ~aux;
	end
	always @(posedge clock_i) begin
		if (wv === 1'b1) begin
			n_wr++;
			l_msg = wm;
			l_data = wd;
		end
		if (clr !== 8'h00) begin
			n_clr++;
			l_clr = clr;
		end
		if (rout_n === 1'b0)
			n_lo++;
	end
	function automatic logic [15:0] par(input logic [15:0] v);
		return {^v[14:0], v[14:0]};
	endfunction
	task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
		tests_run++;
		if (g !== x) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#400000;
		n_fail++;
		print_verdict();
	end
	initial begin
		void'($urandom(64));
		repeat (6) @(posedge clock_i);
		rst_b <= 1'b1;
		repeat (4) @(posedge clock_i);
		host_u.xfer(par(16'h4000), 16, r);
		chk("first", 16'haaaa, r);
		e = 16'h0000;
		n_wr = 0;
		for (k = 0; k < 4; k++) begin
			w = par({2'b01, 5'($urandom_range(31, 1)), 9'($urandom)});
			host_u.xfer(w, 16, r);
			chk("reply", e, r);
			chk("wr", {2'b00, w[13:0]}, {2'b00, l_msg, l_data});
			e = par({2'b00, w[13:9], 9'h000});
		end
		chk("wr_cnt", 16'h0004, 16'(n_wr));
		$display("writes done");
		n_wr = 0;
		for (k = 0; k < 3; k++) begin
			w = par({2'b01, 5'h01, 9'($urandom)});
			w[15] = w[15] ^ (k == 2);
			host_u.xfer(w, k == 0 ? 15 : (k == 1 ? 17 : 16), r);
			host_u.xfer(par(16'h0000), 16, r);
			chk("reject", 16'hc000, r);
		end
		chk("discard", 16'h0000, 16'(n_wr));
		$display("rejects done");
		f = 8'($urandom_range(255, 1));
		@(posedge clock_i);
		flt <= f;
		repeat (8) @(posedge clock_i);
		chk("latch", 16'(f), 16'(st));
		flt <= 8'h00;
		repeat (8) @(posedge clock_i);
		chk("held", 16'(f), 16'(st));
		host_u.xfer(par(16'h0000), 16, r);
		host_u.xfer(par(16'h0000), 16, r);
		chk("status", par(16'(f)), r);
		chk("gone", 16'h0000, 16'(st));
		$display("faults done");
		host_u.xfer(par(16'h4200), 16, r);
		c = 8'($urandom_range(255, 1));
		@(posedge clock_i);
		flt <= f;
		repeat (4) @(posedge clock_i);
		flt <= 8'h00;
		repeat (8) @(posedge clock_i);
		n_clr = 0;
		l_clr = 8'h00;
		host_u.xfer(par({7'h20, 1'b0, c}), 16, r);
		chk("clr", 16'(c), 16'(l_clr));
		chk("clr_len", 16'h0001, 16'(n_clr));
		chk("kept", 16'(f & ~c), 16'(st));
		$display("clears done");
		for (k = 0; k < 2; k++) begin
			@(posedge clock_i);
			n_lo = 0;
			if (k == 0)
				aux_run <= 1'b0;
			else
				aux_half = 20;
			j = 0;
			while (rout_n !== 1'b0 && j < (k == 0 ? 300 : 5200)) begin
				@(posedge clock_i);
				j++;
			end
			chk("rst_out", 16'h0001, 16'(rout_n === 1'b0));
			aux_run <= 1'b1;
			aux_half = 36;
			repeat (40) @(posedge clock_i);
			chk("rst_len", 16'(RST_REC_CYC) + 16'h0001, 16'(n_lo));
			host_u.xfer(par(16'h4000), 16, r);
			chk("restart", 16'haaaa, r);
			host_u.xfer(par(16'h0000), 16, r);
			host_u.xfer(par(16'h0000), 16, r);
			chk("clk_flag", par(16'h3000), r);
		end
		$display("clock faults done");
		print_verdict();
	end
endmodule
`default_nettype wire
